// file: rtl/evt_pub_regs.sv
`timescale 1ns/1ps
`include "evt_pub_defs.svh"

// Notes on behaviour
// - Stopped publish config word at 0x184.
// - Error broadcast on configured channel when enabled.
// - Receive-begun broadcast on configured channel when enabled.
// - Transmit-begun broadcast on configured channel when enabled.
module evt_pub_regs (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    // Event inputs from the two_wire_target engine, one-cycle pulses
    input  wire logic [5:0]  event_in,
    // Published strobes: stopped, error, receive begun, transmit begun
    output logic [3:0]       pub_valid,
    output logic [63:0]      pub_channel,
    // Interrupt
    output logic             irq
);
    import evt_pub_pkg::*;

    // ============================================================
    // State
    logic [5:0]          flag_ff;       // Event flags, bit0 of each flag reg
    logic [5:0]          nxt_flag;
    pub_cfg_type [3:0]   cfg_ff;        // Publish configurations
    pub_cfg_type [3:0]   nxt_cfg;
    logic [5:0]          ista_ff;       // Sticky interrupt status
    logic [5:0]          nxt_ista;
    logic [5:0]          imask_ff;      // Interrupt mask
    logic [5:0]          nxt_imask;
    logic                irq_ff;        // Registered interrupt
    logic                nxt_irq;
    // Bus slave state
    bus_state_type       bus_ff;        // Bus phase
    bus_state_type       nxt_bus;
    logic                wait_ff;       // Registered waitrequest
    logic                nxt_wait;
    logic [31:0]         rdata_ff;      // Read data register
    logic [31:0]         nxt_rdata;
    logic [1:0]          resp_ff;       // Response code
    logic [1:0]          nxt_resp;
    // Decode results
    logic [31:0]         rd_mux;        // Addressed register value
    logic                hit;           // Address is mapped
    logic                wr_go;         // Write takes effect now
    logic                lane0;         // Low byte enabled
    logic                lane_hi;       // Byte 3 enabled
    logic [5:0]          flag_wsel;     // Flag written this cycle
    logic [3:0]          cfg_wsel;      // Config written this cycle
    logic [31:0]         wmask;         // Byte-enable bit mask

    // ============================================================
    // Address decode and read mux
    always_comb begin
        hit       = 1'b1;
        rd_mux    = `UNMAPPED_READ;
        flag_wsel = 6'h00;
        cfg_wsel  = 4'h0;
        case (avs_address)
            // Event flags: only bit 0 is stored
            `OFS_STOPPED_FLAG:   begin
                rd_mux = {31'h0, flag_ff[EV_STOPPED]};
                flag_wsel[EV_STOPPED] = 1'b1;
            end
            `OFS_ERROR_FLAG:     begin
                rd_mux = {31'h0, flag_ff[EV_ERROR]};
                flag_wsel[EV_ERROR] = 1'b1;
            end
            `OFS_RX_BEGUN_FLAG:  begin
                rd_mux = {31'h0, flag_ff[EV_RX_BEGUN]};
                flag_wsel[EV_RX_BEGUN] = 1'b1;
            end
            `OFS_TX_BEGUN_FLAG:  begin
                rd_mux = {31'h0, flag_ff[EV_TX_BEGUN]};
                flag_wsel[EV_TX_BEGUN] = 1'b1;
            end
            `OFS_WRITE_CMD_FLAG: begin
                rd_mux = {31'h0, flag_ff[EV_WRITE]};
                flag_wsel[EV_WRITE] = 1'b1;
            end
            `OFS_READ_CMD_FLAG:  begin
                rd_mux = {31'h0, flag_ff[EV_READ]};
                flag_wsel[EV_READ] = 1'b1;
            end
            `OFS_STOPPED_CFG:    begin
                rd_mux = {cfg_ff[0].en, 15'h0, cfg_ff[0].channel_index};
                cfg_wsel[0] = 1'b1;
            end
            `OFS_ERROR_CFG:      begin
                rd_mux = {cfg_ff[1].en, 15'h0, cfg_ff[1].channel_index};
                cfg_wsel[1] = 1'b1;
            end
            `OFS_RX_BEGUN_CFG:   begin
                rd_mux = {cfg_ff[2].en, 15'h0, cfg_ff[2].channel_index};
                cfg_wsel[2] = 1'b1;
            end
            `OFS_TX_BEGUN_CFG:   begin
                rd_mux = {cfg_ff[3].en, 15'h0, cfg_ff[3].channel_index};
                cfg_wsel[3] = 1'b1;
            end
            // Own interrupt registers, one bit per event
            `OFS_IRQ_STATUS:     rd_mux = {26'h0, ista_ff};
            `OFS_IRQ_MASK:       rd_mux = {26'h0, imask_ff};
            // Unmapped: read zero, answer with a decode error
            default:             hit = 1'b0;
        endcase
    end

    // Write qualifiers
    assign wr_go   = avs_write && (bus_ff == BUS_IDLE);
    assign lane0   = avs_byteenable[0];
    assign lane_hi = avs_byteenable[3];
    assign wmask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ============================================================
    // Bus phase: one wait cycle, answer on the second
    always_comb begin
        nxt_bus   = bus_ff;
        nxt_rdata = rdata_ff;
        nxt_resp  = resp_ff;
        case (bus_ff)
            BUS_IDLE: begin
                // Take a request only in the idle phase
                if (avs_read || avs_write) begin
                    nxt_bus   = BUS_DONE;
                    nxt_rdata = avs_read ? rd_mux : 32'h0000_0000;
                    nxt_resp  = hit ? 2'h0 : 2'h3;
                end
            end
            BUS_DONE: begin
                // Answer cycle lasts exactly one clock
                nxt_bus = BUS_IDLE;
            end
            default: nxt_bus = BUS_IDLE;
        endcase
        // Waitrequest drops only in the answer cycle
        nxt_wait = (nxt_bus == BUS_IDLE);
    end

    // ============================================================
    // Flags, configs and interrupt state
    always_comb begin
        nxt_flag  = flag_ff;
        nxt_cfg   = cfg_ff;
        nxt_imask = imask_ff;
        nxt_ista  = ista_ff;
        // Software writes first, so hardware events override them
        if (wr_go && lane0) begin
            // write of bit 0 stores the flag
            nxt_flag = (flag_ff & ~flag_wsel) | (flag_wsel & {6{avs_writedata[0]}});
            // Mask register takes the whole field
            if (avs_address == `OFS_IRQ_MASK) begin
                nxt_imask = avs_writedata[5:0];
            end
            // Status: a one clears its bit
            if (avs_address == `OFS_IRQ_STATUS) begin
                nxt_ista = ista_ff & ~avs_writedata[5:0];
            end
        end
        // Publish words: channel by lanes 0-1, enable by lane 3
        if (wr_go) begin
            for (int i = 0; i < `NUM_PUB; i++) begin
                if (cfg_wsel[i]) begin
                    nxt_cfg[i].channel_index = (cfg_ff[i].channel_index & ~wmask[15:0])
                                             | (avs_writedata[15:0] & wmask[15:0]);
                    if (lane_hi) begin
                        nxt_cfg[i].en = avs_writedata[`CFG_EN_BIT];
                    end
                end
            end
        end
        // event sets flag, winning over a clear
        nxt_flag = nxt_flag | event_in;
        nxt_ista = nxt_ista | event_in;
        nxt_irq  = |(nxt_ista & nxt_imask);
    end

    // ============================================================
    // Register all state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flag_ff  <= 6'h00;
            cfg_ff   <= '0;
            ista_ff  <= 6'h00;
            imask_ff <= 6'h00;
            irq_ff   <= 1'b0;
            bus_ff   <= BUS_IDLE;
            // Waitrequest is held high through reset
            wait_ff  <= 1'b1;
            rdata_ff <= `REG_RESET;
            resp_ff  <= 2'h0;
        end else begin
            flag_ff  <= nxt_flag;
            cfg_ff   <= nxt_cfg;
            ista_ff  <= nxt_ista;
            imask_ff <= nxt_imask;
            irq_ff   <= nxt_irq;
            bus_ff   <= nxt_bus;
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
            resp_ff  <= nxt_resp;
        end
    end

    assign avs_waitrequest = wait_ff;
    assign avs_readdata    = rdata_ff;
    assign avs_response    = resp_ff;
    assign irq             = irq_ff;

    // ============================================================
    // Publishers for stopped, error, receive begun, transmit begun
    // Each publisher takes one event bit and one configuration word
    evt_pub_if pif [3:0] ();
    localparam logic [2:0] PUB_SRC [4] = '{EV_STOPPED, EV_ERROR, EV_RX_BEGUN, EV_TX_BEGUN};
    for (genvar g = 0; g < `NUM_PUB; g++) begin : g_pub
        assign pif[g].en            = cfg_ff[g].en;
        assign pif[g].channel_index = cfg_ff[g].channel_index;
        assign pif[g].event_pulse   = event_in[PUB_SRC[g]];
        evt_publisher u_pub (
            .mclk        (mclk),
            .sys_rst     (sys_rst),
            .cfg         (pif[g]),
            .pub_valid   (pub_valid[g]),
            .pub_channel (pub_channel[16*g +: 16])
        );
    end

    // ============================================================
    // Checks
    // event sets flag
    flag_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        event_in[EV_STOPPED] |=> flag_ff[EV_STOPPED])
        else $error("stopped flag not set by event");
    read_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        event_in[EV_READ] |=> flag_ff[EV_READ])
        else $error("read command flag not set by event");
    flag_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_go && lane0 && avs_address == `OFS_ERROR_FLAG && !avs_writedata[0] && !event_in[EV_ERROR]
        |=> !flag_ff[EV_ERROR])
        else $error("error flag not cleared by zero write");
    flag_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        flag_ff[EV_TX_BEGUN] && !(wr_go && avs_address == `OFS_TX_BEGUN_FLAG) |=> flag_ff[EV_TX_BEGUN])
        else $error("transmit begun flag dropped without a write");
    stop_cfg_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_go && avs_address == `OFS_STOPPED_CFG && avs_byteenable == 4'hF
        |=> cfg_ff[0].channel_index == $past(avs_writedata[15:0])
            && cfg_ff[0].en == $past(avs_writedata[31]))
        else $error("stopped publish word not stored");
    err_pub_a: assert property (@(posedge mclk) disable iff (sys_rst)
        event_in[EV_ERROR] && cfg_ff[1].en |=> pub_valid[1])
        else $error("error event not published");
    err_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
        event_in[EV_ERROR] && !cfg_ff[1].en |=> !pub_valid[1])
        else $error("error published while disabled");
    rx_pub_a: assert property (@(posedge mclk) disable iff (sys_rst)
        event_in[EV_RX_BEGUN] && cfg_ff[2].en
        |=> pub_valid[2] && pub_channel[47:32] == $past(cfg_ff[2].channel_index))
        else $error("receive begun not published on channel");
    tx_pub_a: assert property (@(posedge mclk) disable iff (sys_rst)
        event_in[EV_TX_BEGUN] && cfg_ff[3].en
        |=> pub_valid[3] && pub_channel[63:48] == $past(cfg_ff[3].channel_index))
        else $error("transmit begun not published on channel");
    // Exactly one wait cycle per transfer
    bus_answer_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    // Unmapped address answers with a decode error
    unmapped_resp_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (avs_read || avs_write) && avs_waitrequest && !hit |=> avs_response == 2'h3)
        else $error("unmapped access without decode error");
    // Unmapped write leaves the publish words alone
    cfg_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_go && !hit |=> $stable(cfg_ff))
        else $error("unmapped write changed a publish word");
    // Status bit cleared by writing one
    ista_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_go && lane0 && avs_address == `OFS_IRQ_STATUS && avs_writedata[1] && !event_in[EV_ERROR]
        |=> !ista_ff[EV_ERROR])
        else $error("error status not cleared by one write");
endmodule

// file: rtl/evt_pub_defs.svh
`ifndef EVT_PUB_DEFS_SVH
`define EVT_PUB_DEFS_SVH

// ============================================================
// Register byte offsets
`define OFS_STOPPED_FLAG     12'h104
`define OFS_ERROR_FLAG       12'h124
`define OFS_RX_BEGUN_FLAG    12'h14C
`define OFS_TX_BEGUN_FLAG    12'h150
`define OFS_WRITE_CMD_FLAG   12'h164
`define OFS_READ_CMD_FLAG    12'h168
`define OFS_STOPPED_CFG      12'h184
`define OFS_ERROR_CFG        12'h1A4
`define OFS_RX_BEGUN_CFG     12'h1CC
`define OFS_TX_BEGUN_CFG     12'h1D0
`define OFS_IRQ_STATUS       12'h400
`define OFS_IRQ_MASK         12'h404

// ============================================================
// Field positions and widths
`define CHAN_IDX_MSB         4'hF
`define CHAN_W               16
`define CFG_EN_BIT           31
`define NUM_EVENTS           6
`define NUM_PUB              4
`define REG_RESET            32'h0000_0000
`define UNMAPPED_READ        32'h0000_0000

`endif

// file: rtl/evt_pub_pkg.sv
package evt_pub_pkg;

    // Index of each event in the six-bit event vectors
    typedef enum logic [2:0] {
        EV_STOPPED  = 3'h0,
        EV_ERROR    = 3'h1,
        EV_RX_BEGUN = 3'h2,
        EV_TX_BEGUN = 3'h3,
        EV_WRITE    = 3'h4,
        EV_READ     = 3'h5
    } event_idx_type;

    // Bus slave phase
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } bus_state_type;

    // One publish configuration word
    typedef struct packed {
        logic        en;
        logic [15:0] channel_index;
    } pub_cfg_type;

endpackage

// file: rtl/evt_pub_if.sv
`timescale 1ns/1ps

// ============================================================
// Publish configuration and event strobe between top and publishers
interface evt_pub_if;
    logic        en;            // Publishing enabled
    logic [15:0] channel_index; // Channel to drive
    logic        event_pulse;   // Event occurred this cycle
    modport ctrl (output en, output channel_index, output event_pulse);
    modport pub  (input en, input channel_index, input event_pulse);
endinterface

// file: rtl/evt_publisher.sv
`timescale 1ns/1ps
`include "evt_pub_defs.svh"

// ============================================================
// One event publisher: registered channel strobe
module evt_publisher (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Configuration and event
    evt_pub_if.pub           cfg,
    // Published strobe
    output logic             pub_valid,
    output logic [15:0]      pub_channel
);
    import evt_pub_pkg::*;

    logic        pub_valid_ff;  // Strobe register
    logic [15:0] pub_chan_ff;   // Channel register
    logic        nxt_pub_valid;
    logic [15:0] nxt_pub_chan;

    // ============================================================
    // Next strobe only when enabled
    always_comb begin
        nxt_pub_valid = cfg.event_pulse & cfg.en;
        nxt_pub_chan  = pub_chan_ff;
        if (cfg.event_pulse && cfg.en) begin
            nxt_pub_chan = cfg.channel_index;
        end
    end

    // Register stage
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pub_valid_ff <= 1'b0;
            pub_chan_ff  <= 16'h0000;
        end else begin
            pub_valid_ff <= nxt_pub_valid;
            pub_chan_ff  <= nxt_pub_chan;
        end
    end

    assign pub_valid   = pub_valid_ff;
    assign pub_channel = pub_chan_ff;

    pub_follow_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cfg.event_pulse && cfg.en |=> pub_valid && pub_channel == $past(cfg.channel_index))
        else $error("publish strobe missing or wrong channel");
    pub_gated_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !(cfg.event_pulse && cfg.en) |=> !pub_valid)
        else $error("publish strobe without enabled event");
endmodule

// file: tb/evt_fabric_model.sv
`timescale 1ns/1ps

// ============================================================
// Far side: event source engine and channel interconnect
module evt_fabric_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Event strobes toward the register block
    output logic [5:0]       event_in,
    // Published strobes from the register block
    input  wire logic [3:0]  pub_valid,
    input  wire logic [63:0] pub_channel
);
    int          hits      [4]; // Strobes seen per publisher
    logic [15:0] last_chan [4]; // Channel of the latest strobe

    initial event_in = 6'h00;

    // Raise events for n cycles, then one quiet cycle
    task automatic fire(input logic [5:0] mask, input int n);
        event_in <= mask;
        repeat (n) @(posedge mclk);
        event_in <= 6'h00;
        @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        for (int g = 0; g < 4; g++) begin
            if (sys_rst) begin
                hits[g] <= 0;
            end else if (pub_valid[g] === 1'b1) begin
                hits[g]      <= hits[g] + 1;
                last_chan[g] <= pub_channel[16*g +: 16];
            end
        end
    end
endmodule

// file: tb/i2c_target_event_publish_regs_tb.sv
`timescale 1ns/1ps
`include "evt_pub_defs.svh"

module i2c_target_event_publish_regs_tb;
    // ============================================================
    // Signals
    logic        mclk;
    logic        sys_rst;
    logic [11:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic [5:0]  event_in;
    logic [3:0]  pub_valid;
    logic [63:0] pub_channel;
    logic        irq;
    int          fails;
    int          comparisons;
    logic [11:0] cfg_ofs  [4] = '{`OFS_STOPPED_CFG, `OFS_ERROR_CFG, `OFS_RX_BEGUN_CFG, `OFS_TX_BEGUN_CFG};
    logic [11:0] flag_ofs [6] = '{`OFS_STOPPED_FLAG, `OFS_ERROR_FLAG, `OFS_RX_BEGUN_FLAG,
                                  `OFS_TX_BEGUN_FLAG, `OFS_WRITE_CMD_FLAG, `OFS_READ_CMD_FLAG};

    evt_pub_regs dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .event_in(event_in), .pub_valid(pub_valid), .pub_channel(pub_channel), .irq(irq));

    evt_fabric_model fab (.mclk(mclk), .sys_rst(sys_rst), .event_in(event_in), .pub_valid(pub_valid),
        .pub_channel(pub_channel));

    // Clock generator
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ============================================================
    // Shared helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) check(32'h1, 32'h0);
        q = avs_readdata;
        r = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0]  r;
        bus(1'b1, a, d, q, r);
    endtask

    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic [1:0]  r;
        bus(1'b0, a, 32'h0000_0000, q, r);
        check(q, exp);
        check({30'h0, r}, (a == 12'h010) ? 32'h0000_0003 : 32'h0000_0000);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset_values();
        for (int i = 0; i < 6; i++) rd_check(flag_ofs[i], 32'h0000_0000);
        for (int g = 0; g < 4; g++) rd_check(cfg_ofs[g], 32'h0000_0000);
        rd_check(`OFS_IRQ_MASK, 32'h0000_0000);
        wr(12'h010, 32'hFFFF_FFFF);
        rd_check(12'h010, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
    endtask

    // Every publisher on its own channel, two events back to back
    task automatic t_publish_all();
        int base [4];
        for (int g = 0; g < 4; g++) begin
            wr(cfg_ofs[g], 32'h8000_0A50 + g);
            rd_check(cfg_ofs[g], 32'h8000_0A50 + g);
            base[g] = fab.hits[g];
        end
        fab.fire(6'h0F, 2);
        @(posedge mclk);
        for (int g = 0; g < 4; g++) begin
            check(32'(fab.hits[g]), 32'(base[g] + 2));
            check({16'h0, fab.last_chan[g]}, 32'h0000_0A50 + g);
            rd_check(flag_ofs[g], 32'h0000_0001);
        end
    endtask

    // Enable cleared: the event is flagged but not broadcast
    task automatic t_disabled();
        int base;
        wr(cfg_ofs[1], 32'h0000_0A51);
        wr(flag_ofs[1], 32'h0000_0000);
        base = fab.hits[1];
        fab.fire(6'h02, 1);
        @(posedge mclk);
        check(32'(fab.hits[1]), 32'(base));
        rd_check(flag_ofs[1], 32'h0000_0001);
    endtask

    // Command flags set, then every flag cleared by writing zero
    task automatic t_flag_clear();
        fab.fire(6'h30, 1);
        rd_check(flag_ofs[4], 32'h0000_0001);
        rd_check(flag_ofs[5], 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            wr(flag_ofs[i], 32'h0000_0000);
            rd_check(flag_ofs[i], 32'h0000_0000);
        end
        wr(flag_ofs[4], 32'hFFFF_FFFF);
        rd_check(flag_ofs[4], 32'h0000_0001);
    endtask

    // Interrupt raised, masked and cleared
    task automatic t_irq();
        wr(`OFS_IRQ_STATUS, 32'h0000_003F);
        wr(`OFS_IRQ_MASK, 32'h0000_0002);
        check({31'h0, irq}, 32'h0000_0000);
        fab.fire(6'h02, 1);
        @(posedge mclk);
        check({31'h0, irq}, 32'h0000_0001);
        fab.fire(6'h01, 1);
        wr(`OFS_IRQ_STATUS, 32'h0000_0002);
        @(posedge mclk);
        check({31'h0, irq}, 32'h0000_0000);
        rd_check(`OFS_IRQ_STATUS, 32'h0000_0001);
    endtask

    // Byte lanes: channel by lanes 0-1, enable by lane 3, flags by lane 0
    task automatic t_lanes();
        int base;
        avs_byteenable <= 4'h3;
        wr(cfg_ofs[2], 32'h0000_1234);
        rd_check(cfg_ofs[2], 32'h8000_1234);
        avs_byteenable <= 4'h8;
        wr(cfg_ofs[2], 32'h0000_FFFF);
        rd_check(cfg_ofs[2], 32'h0000_1234);
        avs_byteenable <= 4'hE;
        wr(flag_ofs[3], 32'h0000_0000);
        avs_byteenable <= 4'hF;
        rd_check(flag_ofs[3], 32'h0000_0001);
        base = fab.hits[2];
        fab.fire(6'h04, 1);
        @(posedge mclk);
        check(32'(fab.hits[2]), 32'(base));
    endtask

    // Reset in mid-run returns every register to zero
    task automatic t_mid_reset();
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd_check(flag_ofs[4], 32'h0000_0000);
        rd_check(cfg_ofs[0], 32'h0000_0000);
        rd_check(`OFS_IRQ_STATUS, 32'h0000_0000);
        check({16'h0, pub_channel[15:0]}, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
    endtask

    // ============================================================
    // Verdict
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #50000;
        fails++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        fails = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reset_values();
        t_publish_all();
        t_disabled();
        t_lanes();
        t_flag_clear();
        t_irq();
        t_mid_reset();
        report_and_stop();
    end
endmodule
